// ---- design/lram_attr_map.sv ----
// Legacy region attribute map: Wishbone register slave and access decoder
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lram_attr_map
	import lram_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire lram_req_s acc_req,
	output lram_route_s acc_route
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lram_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Pick the nibble for a region; index from address bits 16:14
	function automatic logic [3:0] lram_pick(input logic [31:0] map, input logic [2:0] idx);
		return map[{idx, 2'b00} +: 4];
	endfunction

	lram_state_s st_reg;
	lram_state_s st_next;
	logic [5:0] reg_idx;
	logic hit_win;
	logic [3:0] fld;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		reg_idx = acc_req.addr[19:14];
		// Only the low megabyte, regions 30h..3fh (C0000h..FFFFFh)
		hit_win = (acc_req.addr[31:20] == 12'h000) && (reg_idx[5:4] == LRAM_WINDOW_TOP);
		// Regions E0000h/E4000h lie in the high map low nibbles; same layout
		fld = reg_idx[3] ? lram_pick(st_reg.high_map_reg, reg_idx[2:0])
			: lram_pick(st_reg.low_map_reg, reg_idx[2:0]);
		// Bus slave: one wait state, ack drops the cycle after it is given
		case (st_reg.bus_reg)
			LRAM_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					st_next.bus_reg = LRAM_ACK;
					case (wb_adr_i)
						LRAM_LOW_MAP_OFS: begin
							st_next.rdata_reg = st_reg.low_map_reg;
							if (wb_we_i) begin
								st_next.low_map_reg = lram_merge(st_reg.low_map_reg, wb_dat_i,
									wb_sel_i);
							end
						end
						LRAM_HIGH_MAP_OFS: begin
							st_next.rdata_reg = st_reg.high_map_reg;
							if (wb_we_i) begin
								st_next.high_map_reg = lram_merge(st_reg.high_map_reg, wb_dat_i,
									wb_sel_i);
							end
						end
						default: begin
							st_next.rdata_reg = LRAM_UNMAPPED_DATA;
						end
					endcase
				end
			end
			LRAM_ACK: begin
				st_next.bus_reg = LRAM_IDLE;
			end
			default: begin
				st_next.bus_reg = LRAM_IDLE;
			end
		endcase
		// Access routing, one cycle after the request
		st_next.route_reg.valid = acc_req.valid;
		st_next.route_reg.in_window = hit_win;
		st_next.route_reg.field = hit_win ? fld : 4'h0;
		if (!hit_win) begin
			// Outside the window: plain memory, cacheable, PCI unrestricted
			st_next.route_reg.to_memory = acc_req.valid;
			st_next.route_reg.to_pci_master = 1'b0;
			st_next.route_reg.cacheable = acc_req.valid;
			st_next.route_reg.pci_denied = 1'b0;
		end else begin
			// Cache decision is taken ahead of the write check, so a cached
			// write still updates the line even in a non-writable region
			st_next.route_reg.cacheable = acc_req.valid && fld[LRAM_BIT_CACHE];
			st_next.route_reg.pci_denied = acc_req.valid && acc_req.from_pci &&
				!(fld[LRAM_BIT_PCI] && (acc_req.write ? fld[LRAM_BIT_WR] : fld[LRAM_BIT_RD]));
			if (acc_req.write) begin
				st_next.route_reg.to_memory = acc_req.valid && fld[LRAM_BIT_WR];
				st_next.route_reg.to_pci_master = acc_req.valid && !fld[LRAM_BIT_WR];
			end else begin
				st_next.route_reg.to_memory = acc_req.valid && fld[LRAM_BIT_RD];
				st_next.route_reg.to_pci_master = acc_req.valid && !fld[LRAM_BIT_RD];
			end
			if (st_next.route_reg.pci_denied) begin
				st_next.route_reg.to_memory = 1'b0;
				st_next.route_reg.to_pci_master = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_reg.low_map_reg <= LRAM_LOW_MAP_RST;
			st_reg.high_map_reg <= LRAM_HIGH_MAP_RST;
			st_reg.bus_reg <= LRAM_IDLE;
			st_reg.rdata_reg <= LRAM_UNMAPPED_DATA;
			st_reg.route_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_ack_o = (st_reg.bus_reg == LRAM_ACK);
	assign wb_dat_o = st_reg.rdata_reg;
	assign acc_route = st_reg.route_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_low_map_write: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == LRAM_LOW_MAP_OFS &&
		wb_sel_i == 4'hf |=> st_reg.low_map_reg == $past(wb_dat_i))
		else $error("low map write lost");
	a_high_map_read: assert property (
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == LRAM_HIGH_MAP_OFS
		|=> wb_ack_o && wb_dat_o == $past(st_reg.high_map_reg))
		else $error("high map read wrong");
	a_pci_gate: assert property (
		acc_req.valid && acc_req.from_pci && hit_win && !fld[LRAM_BIT_PCI]
		|=> acc_route.pci_denied && !acc_route.to_memory)
		else $error("pci access not denied");
	a_cache_block: assert property (
		acc_req.valid && hit_win && !fld[LRAM_BIT_CACHE] |=> !acc_route.cacheable)
		else $error("cache not inhibited");
	a_write_route: assert property (
		acc_req.valid && !acc_req.from_pci && acc_req.write && hit_win
		|=> acc_route.to_memory == $past(fld[LRAM_BIT_WR]) &&
		acc_route.to_pci_master == !$past(fld[LRAM_BIT_WR]))
		else $error("write routed wrong");
	a_read_route: assert property (
		acc_req.valid && !acc_req.from_pci && !acc_req.write && hit_win
		|=> acc_route.to_memory == $past(fld[LRAM_BIT_RD]) &&
		acc_route.to_pci_master == !$past(fld[LRAM_BIT_RD]))
		else $error("read routed wrong");
	a_cached_write: assert property (
		acc_req.valid && acc_req.write && hit_win && fld[LRAM_BIT_CACHE] |=> acc_route.cacheable)
		else $error("cached write dropped");
	a_outside_win: assert property (
		acc_req.valid && !hit_win |=> acc_route.to_memory && !acc_route.pci_denied &&
		!acc_route.in_window && acc_route.field == 4'h0)
		else $error("outside window affected");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");

	// ----------------------------------------------------------------
	// Map upkeep and routing sanity
	// ----------------------------------------------------------------
	// The maps only move on a taken write; a stray update would silently reroute a region
	a_map_quiet: assert property (
		!(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o)
		|=> $stable(st_reg.low_map_reg) && $stable(st_reg.high_map_reg))
		else $error("map changed without a write");
	a_sel_keep: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'h0
		|=> $stable(st_reg.low_map_reg) && $stable(st_reg.high_map_reg))
		else $error("write without lanes changed a map");
	a_unmapped_write: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i != LRAM_LOW_MAP_OFS &&
		wb_adr_i != LRAM_HIGH_MAP_OFS |=> $stable(st_reg.low_map_reg) &&
		$stable(st_reg.high_map_reg))
		else $error("unmapped write changed a map");
	a_unmapped_read: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
		wb_adr_i != LRAM_LOW_MAP_OFS && wb_adr_i != LRAM_HIGH_MAP_OFS
		|=> wb_ack_o && wb_dat_o == LRAM_UNMAPPED_DATA)
		else $error("unmapped address not read as zero");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	a_window_field: assert property (
		acc_req.valid && hit_win |=> acc_route.in_window && acc_route.field == $past(fld))
		else $error("region field not reported");
	a_pci_allowed: assert property (
		acc_req.valid && acc_req.from_pci && hit_win && fld[LRAM_BIT_PCI] &&
		(acc_req.write ? fld[LRAM_BIT_WR] : fld[LRAM_BIT_RD])
		|=> !acc_route.pci_denied && acc_route.to_memory)
		else $error("permitted pci access refused");
	a_denied_quiet: assert property (
		acc_route.pci_denied |-> !acc_route.to_memory && !acc_route.to_pci_master)
		else $error("denied access still routed");
	a_core_not_denied: assert property (
		acc_req.valid && !acc_req.from_pci |=> !acc_route.pci_denied)
		else $error("core access denied");
	a_cache_read: assert property (
		acc_req.valid && !acc_req.write && hit_win && fld[LRAM_BIT_CACHE] |=> acc_route.cacheable)
		else $error("cacheable read not marked");
	a_route_single: assert property (
		acc_route.valid && !acc_route.pci_denied |->
		acc_route.to_memory != acc_route.to_pci_master)
		else $error("access routed to both or neither");
	a_idle_route: assert property (
		!acc_req.valid |=> !acc_route.valid && !acc_route.to_memory && !acc_route.to_pci_master &&
		!acc_route.cacheable && !acc_route.pci_denied)
		else $error("route raised without a request");

	c_map_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == LRAM_LOW_MAP_OFS);
	c_pci_denied: cover property (acc_route.pci_denied);
	c_fwd_master: cover property (acc_route.to_pci_master && acc_route.in_window);
	c_cached_hit: cover property (acc_route.cacheable && acc_route.in_window);
	c_outside_win: cover property (acc_route.valid && !acc_route.in_window);
endmodule
`default_nettype wire

// ---- inc/lram_pkg.sv ----
// Package: register map, field layout and access carriers for the legacy region attribute map
package lram_pkg;
	localparam logic [15:0] LRAM_LOW_MAP_OFS = 16'h8008;
	localparam logic [15:0] LRAM_HIGH_MAP_OFS = 16'h800c;
	localparam logic [31:0] LRAM_LOW_MAP_RST = 32'h0000_0000;
	localparam logic [31:0] LRAM_HIGH_MAP_RST = 32'h0000_0000;
	localparam int LRAM_BIT_PCI = 3;
	localparam int LRAM_BIT_CACHE = 2;
	localparam int LRAM_BIT_WR = 1;
	localparam int LRAM_BIT_RD = 0;
	localparam logic [1:0] LRAM_WINDOW_TOP = 2'h3;
	localparam logic [31:0] LRAM_UNMAPPED_DATA = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic from_pci;
		logic write;
		logic [31:0] addr;
	} lram_req_s;

	typedef struct packed {
		logic valid;
		logic to_memory;
		logic to_pci_master;
		logic cacheable;
		logic pci_denied;
		logic in_window;
		logic [3:0] field;
	} lram_route_s;

	typedef enum logic [1:0] {
		LRAM_IDLE = 2'b00,
		LRAM_ACK = 2'b01
	} lram_bus_e;

	typedef struct packed {
		logic [31:0] low_map_reg;
		logic [31:0] high_map_reg;
		lram_bus_e bus_reg;
		logic [31:0] rdata_reg;
		lram_route_s route_reg;
	} lram_state_s;
endpackage

// ---- verification/lram_acc_src.sv ----
// Partner model: core and PCI slave side issuing memory accesses
`timescale 1ns/1ps
`default_nettype none
module lram_acc_src
	import lram_pkg::*;
(
	input wire logic core_clk,
	output lram_req_s acc_req
);
	initial acc_req = '0;
	// One access per clock; back to back is legal
	task automatic issue(input logic pci, input logic wr, input logic [31:0] a);
		acc_req <= '{1'b1, pci, wr, a};
		@(posedge core_clk);
	endtask
	// Idle bus shows a changed address so a stale one is never trusted
	task automatic idle();
		acc_req <= '{1'b0, 1'b0, 1'b0, ~acc_req.addr};
	endtask
endmodule
`default_nettype wire

// ---- verification/lram_attr_map_tb.sv ----
// Testbench: register access over Wishbone and region decode checks
`timescale 1ns/1ps
`default_nettype none
module lram_attr_map_tb;
	import lram_pkg::*;
	logic core_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [15:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, lo_m = LRAM_LOW_MAP_RST, hi_m = LRAM_HIGH_MAP_RST, a;
	lram_req_s acc_req;
	lram_route_s acc_route;
	logic [31:0] rq[$];
	lram_route_s eq[$];
	int err_count = 0, n_compared = 0;
	always #20 core_clk = ~core_clk;
	lram_attr_map uut(.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .acc_req, .acc_route);
	lram_acc_src src(.core_clk, .acc_req);
	task automatic check(input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
		for (int b = 0; b < 4; b++) if (s[b]) o[b*8 +: 8] = d[b*8 +: 8];
		return o;
	endfunction
	function automatic lram_route_s exp_route(lram_req_s r);
		lram_route_s e;
		logic [3:0] f;
		logic d;
		e = '0;
		e.valid = 1'b1;
		if (r.addr[31:20] != 12'h000 || r.addr[19:18] != 2'h3) begin
			e.to_memory = 1'b1;
			e.cacheable = 1'b1;
			return e;
		end
		f = r.addr[17] ? hi_m[r.addr[16:14]*4 +: 4] : lo_m[r.addr[16:14]*4 +: 4];
		d = r.write ? f[LRAM_BIT_WR] : f[LRAM_BIT_RD];
		e.in_window = 1'b1;
		e.field = f;
		e.cacheable = f[LRAM_BIT_CACHE];
		if (r.from_pci && !(f[LRAM_BIT_PCI] && d)) e.pci_denied = 1'b1;
		else {e.to_memory, e.to_pci_master} = {d, !d};
		return e;
	endfunction
	// Master holds the request until ack; the expected read word is noted first
	task automatic wb(input logic w, input logic [15:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		i = 0;
		if (!w) rq.push_back(ad == LRAM_LOW_MAP_OFS ? lo_m : ad == LRAM_HIGH_MAP_OFS ? hi_m :
			LRAM_UNMAPPED_DATA);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		{wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {w, ad, d, s};
		do begin
			@(posedge core_clk);
			i++;
		end while (wb_ack_o !== 1'b1);
		check(i, 2);
		if (w && ad == LRAM_LOW_MAP_OFS) lo_m = merge(lo_m, d, s);
		if (w && ad == LRAM_HIGH_MAP_OFS) hi_m = merge(hi_m, d, s);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, rq.pop_front());
		if (acc_route.valid === 1'b1) check(acc_route, eq.pop_front());
	end
	initial begin
		#100us;
		err_count++;
		final_report();
	end
	initial begin
		void'($urandom(32'h860d));
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int k = 0; k < 8; k++) begin
			wb(0, LRAM_LOW_MAP_OFS, 32'h0, 4'h0);
			wb(0, LRAM_HIGH_MAP_OFS, 32'h0, 4'h0);
			wb(0, 16'h8010, 32'h0, 4'h0);
			wb(1, 16'h8010, $urandom, 4'hf);
			wb(1, LRAM_LOW_MAP_OFS, $urandom, 4'($urandom));
			wb(1, LRAM_HIGH_MAP_OFS, $urandom, 4'($urandom));
			// Window edges first, then random spots inside and outside
			for (int j = 0; j < 24; j++) begin
				a = j == 0 ? 32'hbffff : j == 1 ? 32'hfffff : j == 2 ? 32'h100000 : j > 20 ?
					$urandom : {14'h3, 18'($urandom)};
				eq.push_back(exp_route('{1'b1, j[0] ^ k[0], j[1] ^ k[1], a}));
				src.issue(j[0] ^ k[0], j[1] ^ k[1], a);
			end
			src.idle();
			// Mid-run reset: both maps must fall back to their reset values
			if (k == 3) begin
				rst_n <= 1'b0;
				repeat (2) @(posedge core_clk);
				rst_n <= 1'b1;
				lo_m = LRAM_LOW_MAP_RST;
				hi_m = LRAM_HIGH_MAP_RST;
				@(posedge core_clk);
			end
		end
		wb(0, LRAM_LOW_MAP_OFS, 32'h0, 4'h0);
		check(eq.size(), 0);
		final_report();
	end
endmodule
`default_nettype wire
